// ---- rtl/rsq_pkg.sv ----
// Package: register map, field positions and timing for the reset event sequencer
package rsq_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_DES = 8'h00;
    localparam logic [7:0] OFF_FES = 8'h04;
    localparam logic [7:0] OFF_FESS = 8'h08;
    localparam logic [7:0] OFF_FBRE = 8'h0c;
    localparam logic [7:0] OFF_CTRL = 8'h10;
    localparam logic [7:0] OFF_STAT = 8'h14;
    // Control and status field positions
    localparam int CTRL_SWRST_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_PHASE_LSB = 1;
    localparam int STAT_PAD_BIT = 3;
    localparam int STAT_EXIT_OK_BIT = 4;
    localparam int STAT_CLR_PEND_BIT = 5;
    // Reset values
    localparam logic [31:0] RST_FESS = 32'h0000_0000;
    localparam logic [31:0] RST_FBRE = 32'h0000_0000;
    // Clock and phase durations
    localparam int CLK_PERIOD_NS = 50;
    localparam int PH1_TIME_NS = 1000;
    localparam int PH2_TIME_NS = 500;
    localparam int PH3_TIME_NS = 250;
    localparam int PH1_CYC = (PH1_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PH2_CYC = (PH2_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PH3_CYC = (PH3_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Sequencer phases
    typedef enum logic [1:0] {PH_IDLE, PH_FIRST, PH_SECOND, PH_THIRD} rsq_phase_t;
endpackage

// ---- rtl/rsq_clr_sync.sv ----
// Two-stage synchroniser that carries flag clear masks to the status flags
`timescale 1ns/1ps
`default_nettype none
module rsq_clr_sync #(
    parameter int W = 8
) (
    input wire logic i_core_clk,          // System clock
    input wire logic i_resetn,            // Async reset, active low
    input wire logic i_flush,             // Reset event aborts pending clears
    input wire logic [W-1:0] i_clr,       // Clear mask, one-cycle pulse
    output logic [W-1:0] o_clr,           // Clear mask, two cycles later
    output logic o_pend                   // A clear is in the second stage
);
    logic [W-1:0] stage1_r;
    logic [W-1:0] stage2_r;

    // First stage feeds only the second
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            stage1_r <= '0;
            stage2_r <= '0;
        end
        else if (i_flush)
        begin
            // Aborted clear leaves the flag set; pipeline empties for later requests
            stage1_r <= '0;
            stage2_r <= '0;
        end
        else
        begin
            stage1_r <= i_clr;
            stage2_r <= stage1_r;
        end
    end

    assign o_clr = stage2_r;
    assign o_pend = |stage2_r;
endmodule
`default_nettype wire

// ---- rtl/rsq_seq.sv ----
// Reset event flags, clear synchronisation, phase sequencer and Wishbone slave
//
// What this block does
// - A write-one clear of a destructive or functional flag drops the flag two clocks later via a synchroniser.
// - A reset event that aborts a pending clear leaves the flag set, except a functional flag reinitialised by a destructive event, and later clears still work.
// - Functional events start at the third phase only if every firing functional source has its short-select bit set, otherwise at the first.
// - The external reset pad is driven for a source whose pad enable bit is set.
// - Fallback-mode exit stays blocked while any causing condition is active, even with its flag cleared.
//
// Implementation choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module rsq_seq #(
    parameter int N_DES = 8,
    parameter int N_FUN = 8,
    parameter logic [N_FUN-1:0] FALLBACK_SRC = '1
) (
    input wire logic i_core_clk,              // System clock, 20 MHz
    input wire logic i_resetn,                // Async reset, active low
    input wire logic wb_cyc_i,                // Wishbone cycle
    input wire logic wb_stb_i,                // Wishbone strobe
    input wire logic wb_we_i,                 // Wishbone write
    input wire logic [7:0] wb_adr_i,          // Byte address
    input wire logic [3:0] wb_sel_i,          // Byte enables
    input wire logic [31:0] wb_dat_i,         // Write data
    output logic [31:0] wb_dat_o,             // Read data, registered
    output logic wb_ack_o,                    // Acknowledge
    input wire logic [N_DES-1:0] i_des_evt,   // Destructive reset sources
    input wire logic [N_FUN-1:0] i_fun_evt,   // Functional reset sources
    input wire logic [N_FUN-1:0] i_fallback_cond, // Live fallback-mode causes
    output logic o_sys_reset,                 // Reset to the rest of the chip
    output logic o_pad_reset,                 // External reset pad drive
    output logic o_fallback_exit_ok           // Fallback-mode exit permitted
);
    localparam logic [7:0] PH1_N = 8'(rsq_pkg::PH1_CYC);
    localparam logic [7:0] PH2_N = 8'(rsq_pkg::PH2_CYC);
    localparam logic [7:0] PH3_N = 8'(rsq_pkg::PH3_CYC);

    logic [N_DES-1:0] des_r;
    logic [N_FUN-1:0] fes_r;
    logic [N_FUN-1:0] fess_r;
    logic [N_FUN-1:0] fbre_r;
    logic swrst_r;
    logic ack_r;
    logic [31:0] rdata_r;
    rsq_pkg::rsq_phase_t phase_r;
    logic [7:0] cnt_r;
    logic pad_r;
    logic [N_DES-1:0] des_clr;
    logic [N_FUN-1:0] fes_clr;
    logic [N_DES-1:0] des_clr_req;
    logic [N_FUN-1:0] fes_clr_req;
    logic des_pend;
    logic fes_pend;
    logic [N_FUN-1:0] fun_all;
    logic des_hit;
    logic fun_hit;
    logic go_short;
    logic go_pad;
    logic wr_en;
    logic [31:0] wmask;
    logic [31:0] bmask;

    // Byte enables widened to a bit mask
    function automatic logic [31:0] sel_mask(input logic [3:0] sel);
        sel_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // Write lands at the edge where the master sees ack, never a cycle early
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
    // Mask kept as a net so it can be part-selected
    assign bmask = sel_mask(wb_sel_i);
    assign wmask = bmask & wb_dat_i;

    // Software reset enters as functional source zero
    assign fun_all = i_fun_evt | {{(N_FUN-1){1'b0}}, swrst_r};
    assign des_hit = |i_des_evt;
    assign fun_hit = |fun_all;
    // short sequence
    // Short only if every firing functional source asks for it
    assign go_short = !des_hit && ((fun_all & ~fess_r) == '0);
    assign go_pad = des_hit || |(fun_all & fbre_r);

    // Write-one-to-clear requests into the synchroniser
    assign des_clr_req = (wr_en && wb_adr_i == rsq_pkg::OFF_DES) ? wmask[N_DES-1:0] : '0;
    assign fes_clr_req = (wr_en && wb_adr_i == rsq_pkg::OFF_FES) ? wmask[N_FUN-1:0] : '0;

    rsq_clr_sync #(.W(N_DES)) u_des_sync (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_flush(des_hit || fun_hit),
        .i_clr(des_clr_req),
        .o_clr(des_clr),
        .o_pend(des_pend)
    );
    rsq_clr_sync #(.W(N_FUN)) u_fes_sync (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_flush(des_hit || fun_hit),
        .i_clr(fes_clr_req),
        .o_clr(fes_clr),
        .o_pend(fes_pend)
    );

    // destructive flags, set wins over clear
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            des_r <= '0;
        else
            des_r <= (des_r & ~des_clr) | i_des_evt;
    end

    // functional flags; destructive event reinitialises them
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            fes_r <= '0;
        else if (des_hit)
            fes_r <= fun_all;
        else
            fes_r <= (fes_r & ~fes_clr) | fun_all;
    end

    // Configuration registers; survive functional resets, reinit by destructive
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            fess_r <= rsq_pkg::RST_FESS[N_FUN-1:0];
            fbre_r <= rsq_pkg::RST_FBRE[N_FUN-1:0];
        end
        else if (des_hit)
        begin
            fess_r <= rsq_pkg::RST_FESS[N_FUN-1:0];
            fbre_r <= rsq_pkg::RST_FBRE[N_FUN-1:0];
        end
        else if (wr_en && wb_adr_i == rsq_pkg::OFF_FESS)
            fess_r <= (fess_r & ~bmask[N_FUN-1:0]) | wmask[N_FUN-1:0];
        else if (wr_en && wb_adr_i == rsq_pkg::OFF_FBRE)
            fbre_r <= (fbre_r & ~bmask[N_FUN-1:0]) | wmask[N_FUN-1:0];
    end

    // Software reset request, one-cycle pulse; ignored while a sequence runs
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            swrst_r <= 1'b0;
        else
            swrst_r <= wr_en && wb_adr_i == rsq_pkg::OFF_CTRL && wb_sel_i[0]
                && wb_dat_i[rsq_pkg::CTRL_SWRST_BIT] && phase_r == rsq_pkg::PH_IDLE;
    end

    // Phase sequencer; a new event restarts it so the later source wins
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            phase_r <= rsq_pkg::PH_IDLE;
            cnt_r <= '0;
            pad_r <= 1'b0;
        end
        else if (des_hit || fun_hit)
        begin
            if (go_short)
            begin
                phase_r <= rsq_pkg::PH_THIRD;
                cnt_r <= PH3_N - 8'h01;
            end
            else
            begin
                phase_r <= rsq_pkg::PH_FIRST;
                cnt_r <= PH1_N - 8'h01;
            end
            // pad held for the whole sequence
            pad_r <= go_pad;
        end
        else if (cnt_r != 8'h00)
            cnt_r <= cnt_r - 8'h01;
        else
        begin
            case (phase_r)
                rsq_pkg::PH_FIRST:
                begin
                    phase_r <= rsq_pkg::PH_SECOND;
                    cnt_r <= PH2_N - 8'h01;
                end
                rsq_pkg::PH_SECOND:
                begin
                    phase_r <= rsq_pkg::PH_THIRD;
                    cnt_r <= PH3_N - 8'h01;
                end
                rsq_pkg::PH_THIRD:
                begin
                    phase_r <= rsq_pkg::PH_IDLE;
                    pad_r <= 1'b0;
                end
                default:
                    pad_r <= 1'b0;
            endcase
        end
    end

    assign o_sys_reset = phase_r != rsq_pkg::PH_IDLE;
    assign o_pad_reset = pad_r;
    // live condition blocks exit regardless of the flag
    assign o_fallback_exit_ok = !(|(i_fallback_cond & FALLBACK_SRC)) && !(|(fes_r & FALLBACK_SRC));

    // Single-wait acknowledge; drops the cycle after it was given
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            ack_r <= 1'b0;
        else
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
    end
    assign wb_ack_o = ack_r;

    // Read data; unmapped offsets read zero and still acknowledge
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            rdata_r <= '0;
        else if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r)
        begin
            rdata_r <= '0;
            if (wb_adr_i == rsq_pkg::OFF_DES)
                rdata_r[N_DES-1:0] <= des_r;
            else if (wb_adr_i == rsq_pkg::OFF_FES)
                rdata_r[N_FUN-1:0] <= fes_r;
            else if (wb_adr_i == rsq_pkg::OFF_FESS)
                rdata_r[N_FUN-1:0] <= fess_r;
            else if (wb_adr_i == rsq_pkg::OFF_FBRE)
                rdata_r[N_FUN-1:0] <= fbre_r;
            else if (wb_adr_i == rsq_pkg::OFF_STAT)
            begin
                rdata_r[rsq_pkg::STAT_BUSY_BIT] <= o_sys_reset;
                rdata_r[rsq_pkg::STAT_PHASE_LSB +: 2] <= phase_r;
                rdata_r[rsq_pkg::STAT_PAD_BIT] <= pad_r;
                rdata_r[rsq_pkg::STAT_EXIT_OK_BIT] <= o_fallback_exit_ok;
                rdata_r[rsq_pkg::STAT_CLR_PEND_BIT] <= des_pend || fes_pend;
            end
        end
    end
    assign wb_dat_o = rdata_r;
endmodule
`default_nettype wire

// ---- dv/rsq_seq_monitor.sv ----
// Port checker for the reset event sequencer
`timescale 1ns/1ps
`default_nettype none
module rsq_seq_monitor #(
    parameter int N_DES = 8,
    parameter int N_FUN = 8
) (
    input wire logic i_core_clk, // Clock
    input wire logic i_resetn, // Reset, active low
    input wire logic wb_ack_o, // Bus ack
    input wire logic [N_DES-1:0] i_des_evt, // Destructive sources
    input wire logic [N_FUN-1:0] i_fun_evt, // Functional sources
    input wire logic [N_FUN-1:0] i_fallback_cond, // Fallback causes
    input wire logic o_sys_reset, // Sequence running
    input wire logic o_pad_reset, // Pad drive
    input wire logic o_fallback_exit_ok // Exit permitted
);
    // One domain, so one clock and one disable
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_resetn);
    // Long sequence keeps reset up for its first 8 cycles
    sequence s_long;
        o_sys_reset [*8];
    endsequence
    // Exit may reopen only two edges after a clear was taken; destructive reinit excluded
    sequence s_flag_drop;
        $rose(o_fallback_exit_ok) && ($past(i_fallback_cond) == '0) && ($past(i_des_evt) == '0);
    endsequence
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    property p_long_des;
        (|i_des_evt) |=> s_long;
    endproperty
    property p_pad_des;
        (|i_des_evt) |=> o_pad_reset;
    endproperty
    property p_pad_in_seq;
        o_pad_reset |-> o_sys_reset;
    endproperty
    property p_exit_block;
        (|i_fallback_cond) |-> !o_fallback_exit_ok;
    endproperty
    property p_flag_set;
        (|i_fun_evt) |=> !o_fallback_exit_ok;
    endproperty
    property p_clear_delay;
        s_flag_drop |-> $past(wb_ack_o, 3);
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_long_des: assert property (p_long_des) else $error("long sequence cut short");
    a_pad_des: assert property (p_pad_des) else $error("pad not driven");
    a_pad_in_seq: assert property (p_pad_in_seq) else $error("pad outside sequence");
    a_exit_block: assert property (p_exit_block) else $error("exit allowed with live cause");
    a_flag_set: assert property (p_flag_set) else $error("event flag not set");
    a_clear_delay: assert property (p_clear_delay) else $error("flag dropped off time");
endmodule
bind rsq_seq rsq_seq_monitor #(.N_DES(N_DES), .N_FUN(N_FUN)) i_mon (.i_core_clk(i_core_clk),
    .i_resetn(i_resetn), .wb_ack_o(wb_ack_o), .i_des_evt(i_des_evt), .i_fun_evt(i_fun_evt),
    .i_fallback_cond(i_fallback_cond), .o_sys_reset(o_sys_reset), .o_pad_reset(o_pad_reset),
    .o_fallback_exit_ok(o_fallback_exit_ok));
`default_nettype wire

// ---- dv/rsq_pad_model.sv ----
// External reset pad with pull-up
`timescale 1ns/1ps
`default_nettype none
module rsq_pad_model (
    input wire logic i_pad_drive, // Device pad drive
    output logic o_pad_n // Pad level, low when asserted
);
    // pad pulled low
    // Released pad returns to the pull-up, never the last value
    assign o_pad_n = (i_pad_drive === 1'b1) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ---- dv/rsq_seq_tb.sv ----
// Self-checking bench for the reset event sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %0t got %h", $time, g); end end
module rsq_seq_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, pd;
    logic [7:0] adr = 8'h00, des = 8'h00, fun = 8'h00, fbc = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    wire logic [31:0] dat_o;
    wire logic ack, sysr, padr, exok, pad_n;
    int num_errors = 0;
    int check_count = 0;
    int len;
    rsq_seq i_dut (.i_core_clk(clk), .i_resetn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .i_des_evt(des),
        .i_fun_evt(fun), .i_fallback_cond(fbc), .o_sys_reset(sysr), .o_pad_reset(padr), .o_fallback_exit_ok(exok));
    rsq_pad_model i_pad (.i_pad_drive(padr), .o_pad_n(pad_n));
    // Free-running 20 MHz clock
    initial
    begin
        forever #25 clk = ~clk;
    end
    task automatic end_sim();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n >= 100)
        begin
            num_errors++;
            end_sim();
        end
    endtask
    // Classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        wdat <= d;
        for (n = 0; n < 100 && ack !== 1'b1; n++)
            @(posedge clk);
        tmo(n);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic pulse(input logic [7:0] d, input logic [7:0] f);
        @(posedge clk);
        des <= d;
        fun <= f;
        @(posedge clk);
        des <= 8'h00;
        fun <= 8'h00;
    endtask
    task automatic idle();
        int n;
        for (n = 0; n < 100 && sysr !== 1'b0; n++)
            @(posedge clk);
        tmo(n);
    endtask
    // Fire sources, count reset cycles and note the pad
    task automatic seq_len(input logic [7:0] d, input logic [7:0] f);
        pulse(d, f);
        #1;
        pd = 1'b0;
        for (len = 0; len < 100 && sysr === 1'b1; len++)
        begin
            if (pad_n === 1'b0)
                pd = 1'b1;
            @(posedge clk);
            #1;
        end
        tmo(len);
    endtask
    task automatic t_regs();
        wb(0, rsq_pkg::OFF_FESS, 32'h0);
        `CHK(rdat, rsq_pkg::RST_FESS)
        wb(0, rsq_pkg::OFF_FBRE, 32'h0);
        `CHK(rdat, rsq_pkg::RST_FBRE)
        wb(0, rsq_pkg::OFF_STAT, 32'h0);
        `CHK(rdat, 32'h1 << rsq_pkg::STAT_EXIT_OK_BIT)
        wb(0, 8'h20, 32'h0);
        `CHK(rdat, 32'h0)
    endtask
    task automatic t_seq();
        wb(1, rsq_pkg::OFF_FESS, 32'h02);
        wb(1, rsq_pkg::OFF_FBRE, 32'h04);
        seq_len(8'h00, 8'h02);
        `CHK(len, rsq_pkg::PH3_CYC)
        `CHK(pd, 1'b0)
        seq_len(8'h00, 8'h04);
        `CHK(len, rsq_pkg::PH1_CYC + rsq_pkg::PH2_CYC + rsq_pkg::PH3_CYC)
        `CHK(pd, 1'b1)
    endtask
    task automatic t_clear();
        wb(1, rsq_pkg::OFF_FES, 32'hff);
        #1;
        `CHK(exok, 1'b0)
        @(posedge clk);
        #1;
        `CHK(exok, 1'b0)
        @(posedge clk);
        #1;
        `CHK(exok, 1'b1)
    endtask
    task automatic t_abort();
        seq_len(8'h00, 8'h01);
        fork
            wb(1, rsq_pkg::OFF_FES, 32'h01);
            begin
                repeat (2) @(posedge clk);
                fun <= 8'h10;
                @(posedge clk);
                fun <= 8'h00;
            end
        join
        wb(0, rsq_pkg::OFF_FES, 32'h0);
        `CHK(rdat, 32'h11)
        idle();
        wb(1, rsq_pkg::OFF_FES, 32'hff);
        // Clear needs two edges before a read can see it
        @(posedge clk);
        wb(0, rsq_pkg::OFF_FES, 32'h0);
        `CHK(rdat, 32'h0)
    endtask
    task automatic t_fallback();
        fbc <= 8'h08;
        seq_len(8'h00, 8'h08);
        wb(1, rsq_pkg::OFF_FES, 32'hff);
        repeat (3) @(posedge clk);
        `CHK(exok, 1'b0)
        fbc <= 8'h00;
        @(posedge clk);
        `CHK(exok, 1'b1)
        // cause removed before the flag clear
        fbc <= 8'h04;
        seq_len(8'h00, 8'h04);
        @(posedge clk);
        fbc <= 8'h00;
        @(posedge clk);
        `CHK(exok, 1'b0)
        wb(1, rsq_pkg::OFF_FES, 32'hff);
        repeat (3) @(posedge clk);
        `CHK(exok, 1'b1)
    endtask
    task automatic t_swrst();
        wb(0, rsq_pkg::OFF_FES, 32'h0);
        `CHK(rdat, 32'h0)
        wb(1, rsq_pkg::OFF_CTRL, 32'h1);
        repeat (3) @(posedge clk);
        `CHK(sysr, 1'b1)
        idle();
        wb(0, rsq_pkg::OFF_FES, 32'h0);
        `CHK(rdat, 32'h01)
    endtask
    task automatic t_des();
        seq_len(8'h20, 8'h00);
        `CHK(pd, 1'b1)
        wb(0, rsq_pkg::OFF_DES, 32'h0);
        `CHK(rdat, 32'h20)
        wb(0, rsq_pkg::OFF_FESS, 32'h0);
        `CHK(rdat, 32'h0)
        pulse(8'h01, 8'h00);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        wb(0, rsq_pkg::OFF_DES, 32'h0);
        `CHK(rdat, 32'h0)
    endtask
    // Reset for four cycles, then the scenarios
    initial
    begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_seq();
        t_clear();
        t_abort();
        t_fallback();
        t_swrst();
        t_des();
        end_sim();
    end
endmodule
`default_nettype wire
